/* sixteen_bit_timer_counter.sv */
`timescale 1ns/10ps
`include "timer_params.svh"

module sixteen_bit_timer_counter (
	input  logic                          pclk,
	input  logic                          presetn,
	input  logic [7:0]                    paddr,
	input  logic                          psel,
	input  logic                          penable,
	input  logic                          pwrite,
	input  logic [31:0]                   pwdata,
	input  logic [3:0]                    pstrb,
	output logic [31:0]                   prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  logic                          counter_input_pin,
	input  timer_types_pkg::power_mode_t  power_mode,
	input  logic                          deep_stop_entry,
	input  logic                          prescaler_tap_select,
	input  logic                          low_freq_tick,
	output logic                          match_interrupt
);
	timer_types_pkg::control_t   ctrl_q;
	timer_types_pkg::control_t   ctrl_d;
	timer_types_pkg::run_state_t run_q;
	timer_types_pkg::run_state_t run_d;
	logic [15:0]                 period_q;
	logic [15:0]                 period_stage_q;
	logic [15:0]                 duty_q;
	logic [15:0]                 duty_stage_q;
	logic [15:0]                 cnt_q;
	logic [15:0]                 cnt_d;
	logic                        period_pend_q;
	logic                        duty_pend_q;
	logic                        pin_clean;
	logic                        pin_prev_q;
	logic [`DIV_WIDTH-1:0]       div_q;
	logic [2:0]                  lf_div_q;
	logic                        pready_q;
	logic                        pslverr_q;
	logic [31:0]                 prdata_q;
	logic                        irq_q;
	logic                        irq_d;

	// ==========================================================
	// Helpers
	function automatic logic [15:0] merge_stage(input logic [15:0] stage,
		input logic [31:0] wdata, input logic [3:0] strb);
		merge_stage = stage;
		if (strb[0]) merge_stage[7:0] = wdata[7:0];
		if (strb[1]) merge_stage[15:8] = wdata[15:8];
	endfunction

	function automatic logic tap_hit(input logic [`DIV_WIDTH-1:0] div, input logic [1:0] sel);
		case (sel)
			`CLK_SEL_SLOW: tap_hit = &div[`TAP_SLOW_MSB:0];
			`CLK_SEL_MID:  tap_hit = &div[`TAP_MID_MSB:0];
			`CLK_SEL_FAST: tap_hit = &div[`TAP_FAST_MSB:0];
			default:       tap_hit = 1'b0;
		endcase
	endfunction

	// ==========================================================
	// APB decode
	wire apb_access  = psel & penable;
	wire apb_done    = apb_access & pready_q;
	wire hit_period  = paddr == `OFS_PERIOD;
	wire hit_duty    = paddr == `OFS_DUTY;
	wire hit_control = paddr == `OFS_CONTROL;
	wire hit_status  = paddr == `OFS_STATUS;
	wire addr_hit    = hit_period | hit_duty | hit_control | hit_status;
	wire period_wr   = apb_done & pwrite & hit_period;
	// Duty is only software-writable in pulse output mode
	wire duty_wr     = apb_done & pwrite & hit_duty & (ctrl_q.mode == `MODE_PULSE_OUT);
	wire ctrl_wr     = apb_done & pwrite & hit_control & pstrb[0];
	wire quiet       = ~ctrl_wr & ~deep_stop_entry;

	wire [31:0] rdata_mux =
		hit_period  ? {16'h0000, period_q} :
		hit_duty    ? {16'h0000, duty_q} :
		hit_control ? {24'h000000, ctrl_q} :
		hit_status  ? {12'h000, duty_pend_q, period_pend_q, run_q, cnt_q} :
		32'h0000_0000;

	// One wait state: pready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= apb_access & ~pready_q;
			pslverr_q <= apb_access & ~pready_q & ~addr_hit;
			prdata_q  <= (apb_access & ~pready_q) ? rdata_mux : prdata_q;
		end
	end

	// ==========================================================
	// Control register
	always_comb begin
		ctrl_d = ctrl_wr ? timer_types_pkg::control_t'(pwdata[7:0]) : ctrl_q;
		// Deep stop wins over the start field of a concurrent software write
		if (deep_stop_entry) begin
			ctrl_d.start = `START_STOP;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= timer_types_pkg::control_t'(`CTRL_RESET);
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// ==========================================================
	// Counter input pin and source clock
	wire filter_bypass = (power_mode == timer_types_pkg::PWR_LOW_SPEED) ||
		(power_mode == timer_types_pkg::PWR_SLEEP);

	pin_noise_filter #(
		.REJECT_CYCLES (`NOISE_REJECT_CYCLES)
	) u_pin_filter (
		.pclk      (pclk),
		.presetn   (presetn),
		.pin_raw   (counter_input_pin),
		.bypass    (filter_bypass),
		.pin_clean (pin_clean)
	);

	wire pin_rise      = pin_clean & ~pin_prev_q;
	wire pin_fall      = ~pin_clean & pin_prev_q;
	wire count_edge    = (ctrl_q.start == `START_FALL) ? pin_fall : pin_rise;
	wire opp_edge      = (ctrl_q.start == `START_FALL) ? pin_rise : pin_fall;
	wire ext_clock     = ctrl_q.clk_sel == `CLK_EXTERNAL;
	wire use_lf        = prescaler_tap_select | filter_bypass;
	wire lf_clk_tick   = low_freq_tick & (lf_div_q == `LF_DIV_LAST);
	// Faster taps are unavailable while the slow clock drives the core
	wire internal_tick = ((ctrl_q.clk_sel == `CLK_SEL_SLOW) && use_lf) ? lf_clk_tick :
		(!filter_bypass && tap_hit(div_q, ctrl_q.clk_sel));
	wire src_tick      = ext_clock ? count_edge : internal_tick;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_prev_q <= 1'b0;
			div_q      <= '0;
			lf_div_q   <= 3'h0;
		end else begin
			pin_prev_q <= pin_clean;
			div_q      <= div_q + `DIV_WIDTH'(1);
			lf_div_q   <= low_freq_tick ? lf_div_q + 3'h1 : lf_div_q;
		end
	end

	// ==========================================================
	// Mode decode
	wire mode_tce   = ctrl_q.mode == `MODE_TCE;
	wire started    = ctrl_q.start != `START_STOP;
	wire is_timer   = mode_tce & (ctrl_q.start == `START_CMD);
	wire is_trigger = mode_tce & ctrl_q.start[1] & ~ext_clock;
	wire is_event   = mode_tce & ctrl_q.start[1] & ext_clock;
	wire counting   = run_q == timer_types_pkg::RUN_COUNTING;
	wire match      = cnt_q == period_q;
	wire capture_en = ctrl_q.opt & (is_timer | is_event) & counting & src_tick;

	// ==========================================================
	// Counter state machine
	always_comb begin
		run_d = run_q;
		cnt_d = cnt_q;
		irq_d = 1'b0;
		if (!started || !mode_tce) begin
			// Window, width and pulse modes are not counted here
			run_d = timer_types_pkg::RUN_STOPPED;
			cnt_d = 16'h0000;
		end else begin
			case (run_q)
				timer_types_pkg::RUN_STOPPED: begin
					run_d = is_trigger ? timer_types_pkg::RUN_ARMED
						: timer_types_pkg::RUN_COUNTING;
				end
				timer_types_pkg::RUN_ARMED: begin
					if (count_edge) begin
						run_d = timer_types_pkg::RUN_COUNTING;
					end
				end
				timer_types_pkg::RUN_COUNTING: begin
					if (is_event) begin
						if (opp_edge && match) begin
							cnt_d = 16'h0000;
							irq_d = 1'b1;
						end else if (src_tick) begin
							cnt_d = cnt_q + 16'h0001;
						end
					end else if (src_tick && match) begin
						cnt_d = 16'h0000;
						irq_d = 1'b1;
						if (is_trigger) begin
							run_d = timer_types_pkg::RUN_ARMED;
						end
					end else if (is_trigger && ctrl_q.opt && opp_edge) begin
						cnt_d = 16'h0000;
						run_d = timer_types_pkg::RUN_ARMED;
					end else if (src_tick) begin
						cnt_d = cnt_q + 16'h0001;
					end
				end
				default: begin
					run_d = timer_types_pkg::RUN_STOPPED;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_q <= timer_types_pkg::RUN_STOPPED;
			cnt_q <= 16'h0000;
			irq_q <= 1'b0;
		end else begin
			run_q <= run_d;
			cnt_q <= cnt_d;
			irq_q <= irq_d;
		end
	end

	// ==========================================================
	// Period and duty registers, staged behind the upper byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_stage_q <= `DATA_RESET;
			period_q       <= `DATA_RESET;
			period_pend_q  <= 1'b0;
		end else begin
			period_stage_q <= period_wr ? merge_stage(period_stage_q, pwdata, pstrb) : period_stage_q;
			period_q       <= (period_pend_q & src_tick) ? period_stage_q : period_q;
			period_pend_q  <= (period_wr & pstrb[1]) | (period_pend_q & ~src_tick);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			duty_stage_q <= `DATA_RESET;
			duty_q       <= `DATA_RESET;
			duty_pend_q  <= 1'b0;
		end else begin
			duty_stage_q <= duty_wr ? merge_stage(duty_stage_q, pwdata, pstrb) : duty_stage_q;
			if (capture_en) begin
				duty_q <= cnt_q;
			end else if (duty_pend_q & src_tick) begin
				duty_q <= duty_stage_q;
			end
			duty_pend_q  <= (duty_wr & pstrb[1]) | (duty_pend_q & ~src_tick);
		end
	end

	assign prdata          = prdata_q;
	assign pready          = pready_q;
	assign pslverr         = pslverr_q;
	assign match_interrupt = irq_q;

	// ==========================================================
	// Checks
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence trig_counting_s;
		counting && is_trigger && quiet;
	endsequence

	sequence halted_clear_s;
		run_q == timer_types_pkg::RUN_ARMED && cnt_q == 16'h0000;
	endsequence

	period_apply_a: assert property (
		$changed(period_q) |-> $past(src_tick) && $past(period_pend_q))
		else $error("period changed without pending upper byte and tick");

	low_byte_hold_a: assert property (
		period_wr && !pstrb[1] && !period_pend_q |=> !period_pend_q)
		else $error("lower byte write armed the period update");

	deep_stop_a: assert property (
		deep_stop_entry |=> ctrl_q.start == `START_STOP
			##1 run_q == timer_types_pkg::RUN_STOPPED && cnt_q == 16'h0000)
		else $error("deep stop did not stop and clear the counter");

	capture_a: assert property (
		capture_en |=> duty_q == $past(cnt_q))
		else $error("auto-capture missed the counter value");

	timer_wrap_a: assert property (
		is_timer && counting && src_tick && match && quiet
			|=> cnt_q == 16'h0000 && match_interrupt)
		else $error("timer match did not clear and interrupt");

	timer_inc_a: assert property (
		is_timer && counting && src_tick && !match && quiet
			|=> cnt_q == $past(cnt_q) + 16'h0001 && !match_interrupt)
		else $error("timer did not advance by one");

	trig_start_a: assert property (
		run_q == timer_types_pkg::RUN_ARMED && is_trigger && count_edge && quiet |=> counting)
		else $error("trigger edge did not start counting");

	armed_hold_a: assert property (
		run_q == timer_types_pkg::RUN_ARMED && is_trigger && !count_edge && quiet
			|=> halted_clear_s)
		else $error("counter moved before trigger edge");

	opp_halt_a: assert property (
		trig_counting_s ##0 (ctrl_q.opt && opp_edge && !(src_tick && match))
			|=> halted_clear_s ##0 !match_interrupt)
		else $error("opposite edge did not halt silently");

	match_halt_a: assert property (
		trig_counting_s ##0 (src_tick && match) |=> halted_clear_s ##0 match_interrupt)
		else $error("trigger mode match did not halt with interrupt");

	trig_ignore_a: assert property (
		trig_counting_s ##0 (!ctrl_q.opt && !(src_tick && match)) |=> counting)
		else $error("edge disturbed counting without trigger-stop");

	event_match_a: assert property (
		is_event && counting && opp_edge && match && quiet
			|=> cnt_q == 16'h0000 && match_interrupt)
		else $error("event match at opposite edge not handled");

	mode_decode_a: assert property (
		!mode_tce && quiet |=> run_q == timer_types_pkg::RUN_STOPPED && cnt_q == 16'h0000)
		else $error("counter ran outside counter mode");

endmodule

/* timer_params.svh */
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// ==========================================================
// Register map
`define OFS_PERIOD      8'h00
`define OFS_DUTY        8'h04
`define OFS_CONTROL     8'h08
`define OFS_STATUS      8'h0C
`define DATA_RESET      16'hFFFF
`define CTRL_RESET      8'h00

// ==========================================================
// Control field encodings
`define START_STOP      2'h0
`define START_CMD       2'h1
`define START_FALL      2'h3
`define MODE_TCE        2'h0
`define MODE_PULSE_OUT  2'h3
`define CLK_SEL_SLOW    2'h0
`define CLK_SEL_MID     2'h1
`define CLK_SEL_FAST    2'h2
`define CLK_EXTERNAL    2'h3

// ==========================================================
// Prescaler and timing
`define DIV_WIDTH       11
`define TAP_SLOW_MSB    10
`define TAP_MID_MSB     6
`define TAP_FAST_MSB    2
`define LF_DIV_LAST     3'h7
`define PCLK_HZ         10000000
`define HF_CLK_HZ       10000000
`define NOISE_REJECT_HF 4
`define NOISE_REJECT_CYCLES ((`NOISE_REJECT_HF * `PCLK_HZ) / `HF_CLK_HZ)

`endif

/* timer_types_pkg.sv */
package timer_types_pkg;

	typedef enum logic [1:0] {
		RUN_STOPPED  = 2'h0,
		RUN_ARMED    = 2'h1,
		RUN_COUNTING = 2'h3
	} run_state_t;

	typedef enum logic [1:0] {
		PWR_NORMAL    = 2'h0,
		PWR_IDLE      = 2'h1,
		PWR_LOW_SPEED = 2'h2,
		PWR_SLEEP     = 2'h3
	} power_mode_t;

	typedef struct packed {
		logic       tff;
		logic       opt;
		logic [1:0] start;
		logic [1:0] clk_sel;
		logic [1:0] mode;
	} control_t;

endpackage

/* pin_noise_filter.sv */
`timescale 1ns/10ps
module pin_noise_filter #(
	parameter int REJECT_CYCLES = 4
) (
	input  logic pclk,
	input  logic presetn,
	input  logic pin_raw,
	input  logic bypass,
	output logic pin_clean
);
	localparam int CW = $clog2(REJECT_CYCLES + 1);
	localparam logic [CW-1:0] REJECT_LAST = CW'(REJECT_CYCLES);

	logic          sync1_q;
	logic          sync2_q;
	logic          clean_q;
	logic [CW-1:0] stable_q;

	// ==========================================================
	// Filter: a new level must outlast the reject window
	wire differs = sync2_q != clean_q;
	wire accept  = bypass | (differs & (stable_q == REJECT_LAST));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q  <= 1'b0;
			sync2_q  <= 1'b0;
			clean_q  <= 1'b0;
			stable_q <= '0;
		end else begin
			sync1_q  <= pin_raw;
			sync2_q  <= sync1_q;
			clean_q  <= accept ? sync2_q : clean_q;
			stable_q <= (differs & ~accept) ? stable_q + CW'(1) : '0;
		end
	end

	assign pin_clean = clean_q;

	// ==========================================================
	// Checks
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	noise_reject_a: assert property (
		!$past(bypass) && $changed(clean_q) |-> $past(stable_q) == REJECT_LAST)
		else $error("filtered pin changed before reject window elapsed");

	filter_bypass_a: assert property (
		bypass |=> clean_q == $past(sync2_q))
		else $error("bypassed filter did not follow synchronised pin");

endmodule

/* pulse_source.sv */
`timescale 1ns/10ps
// ==========================================================
// External pulse source on the counter input pin
module pulse_source (
	input  logic pclk,
	output logic pin
);
	// Idle low between pulses; edges land just after a clock edge
	initial pin = 1'b0;

	// Caller picks widths; five or more cycles guarantees detection
	// Each level held whole cycles; widths are not checked and zero is allowed
	task automatic pulse(input int high_cyc, input int low_cyc);
		begin
			@(posedge pclk);
			pin <= 1'b1;
			repeat (high_cyc) @(posedge pclk);
			pin <= 1'b0;
			repeat (low_cyc) @(posedge pclk);
		end
	endtask
endmodule

/* sixteen_bit_timer_counter_tb_top.sv */
`timescale 1ns/10ps
`include "timer_params.svh"
module sixteen_bit_timer_counter_tb_top;
	logic                         pclk;
	logic                         presetn;
	logic [7:0]                   paddr;
	logic                         psel;
	logic                         penable;
	logic                         pwrite;
	logic [31:0]                  pwdata;
	logic [3:0]                   pstrb;
	logic [31:0]                  prdata;
	logic                         pready;
	logic                         pslverr;
	logic                         pin;
	timer_types_pkg::power_mode_t power_mode;
	logic                         deep_stop_entry;
	logic                         tap_sel;
	logic                         lf_tick;
	logic                         match_interrupt;
	logic [2:0]                   lf_div;
	int                           err_count;
	int                           samples_checked;
	int                           cyc;
	int                           irq_count;
	int                           irq_last;
	int                           irq_prev;

	sixteen_bit_timer_counter sixteen_bit_timer_counter_inst (
		.pclk                 (pclk),
		.presetn              (presetn),
		.paddr                (paddr),
		.psel                 (psel),
		.penable              (penable),
		.pwrite               (pwrite),
		.pwdata               (pwdata),
		.pstrb                (pstrb),
		.prdata               (prdata),
		.pready               (pready),
		.pslverr              (pslverr),
		.counter_input_pin    (pin),
		.power_mode           (power_mode),
		.deep_stop_entry      (deep_stop_entry),
		.prescaler_tap_select (tap_sel),
		.low_freq_tick        (lf_tick),
		.match_interrupt      (match_interrupt)
	);

	pulse_source pulse_source_inst (
		.pclk (pclk),
		.pin  (pin)
	);

	// ==========================================================
	// Clock, reset, stand-in low-frequency tick, watchdog
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		paddr = 8'h00;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0;
		pstrb = 4'h0;
		power_mode = timer_types_pkg::PWR_NORMAL;
		deep_stop_entry = 1'b0;
		tap_sel = 1'b0;
		lf_div = 3'h0;
		err_count = 0;
		samples_checked = 0;
		cyc = 0;
		irq_count = 0;
		irq_last = 0;
		irq_prev = 0;
	end
	always #50 pclk = ~pclk;
	assign lf_tick = (lf_div == 3'h7);
	always @(posedge pclk) begin
		lf_div <= lf_div + 3'h1;
		cyc <= cyc + 1;
		if (match_interrupt === 1'b1) begin
			irq_count <= irq_count + 1;
			irq_prev <= irq_last;
			irq_last <= cyc;
		end
		if (cyc == 20000) begin
			err_count++;
			stop_test();
		end
	end

	// ==========================================================
	// Shared helpers
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		begin
			samples_checked++;
			if (seen !== exp) begin
				err_count++;
				$display("ERROR %s expected %h seen %h", name, exp, seen);
			end
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] r, output logic e);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			pstrb <= s;
			@(posedge pclk);
			penable <= 1'b1;
			// Only the bench watchdog ends a wait that never completes
			do begin
				@(posedge pclk);
			end while (pready !== 1'b1);
			r = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, s, r, e);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, 4'h0, r, e);
	endtask

	// Stop with fields kept, then change mode and clock while stopped
	// Period applies on the previous fast clock during the wait
	task automatic setup(input logic [15:0] per, input logic [7:0] cfg);
		logic [31:0] r;
		begin
			rd(`OFS_CONTROL, r);
			wr(`OFS_CONTROL, {24'h0, r[7:6], 2'b00, r[3:0]}, 4'h1);
			wr(`OFS_PERIOD, {16'h0, per}, 4'h3);
			repeat (20) @(posedge pclk);
			wr(`OFS_CONTROL, {24'h0, 1'b0, cfg[6], 2'b00, cfg[3:0]}, 4'h1);
			wr(`OFS_CONTROL, {24'h0, 1'b0, cfg[6:0]}, 4'h1);
		end
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset_and_map;
		logic [31:0] r;
		logic        e;
		begin
			rd(`OFS_PERIOD, r);
			chk("period reset", r, 32'h0000FFFF);
			rd(`OFS_CONTROL, r);
			chk("control reset", r, 32'h0);
			wr(`OFS_DUTY, 32'h1234, 4'h3);
			repeat (20) @(posedge pclk);
			rd(`OFS_DUTY, r);
			chk("duty refused outside pulse mode", r, 32'h0000FFFF);
			apb(1'b0, 8'h10, 32'h0, 4'h0, r, e);
			chk("unmapped error", {31'h0, e}, 32'h1);
			chk("unmapped data", r, 32'h0);
		end
	endtask

	task automatic t_staged_bytes;
		logic [31:0] r;
		begin
			// Fast tap so a staged value has ticks to apply on
			wr(`OFS_CONTROL, 32'h08, 4'h1);
			wr(`OFS_PERIOD, 32'h00CD, 4'h1);
			repeat (40) @(posedge pclk);
			rd(`OFS_PERIOD, r);
			chk("lower byte alone", r, 32'h0000FFFF);
			wr(`OFS_PERIOD, 32'hAB00, 4'h2);
			repeat (40) @(posedge pclk);
			rd(`OFS_PERIOD, r);
			chk("upper byte applies", r, 32'h0000ABCD);
			wr(`OFS_CONTROL, 32'h0B, 4'h1);
			wr(`OFS_DUTY, 32'h0005, 4'h3);
			repeat (40) @(posedge pclk);
			rd(`OFS_DUTY, r);
			chk("duty in pulse mode", r, 32'h00000005);
			wr(`OFS_CONTROL, 32'h08, 4'h1);
		end
	endtask

	task automatic t_timer_capture;
		logic [31:0] r;
		int          seen;
		begin
			setup(16'h0003, 8'h58);
			seen = irq_count;
			repeat (120) @(posedge pclk);
			chk("timer irq seen", {31'h0, irq_count > seen + 1}, 32'h1);
			// Four ticks of eight cycles between matches
			chk("timer irq interval", irq_last - irq_prev, 32);
			rd(`OFS_DUTY, r);
			chk("captured count range", {16'h0, r[15:2]}, 32'h0);
			deep_stop_entry <= 1'b1;
			@(posedge pclk);
			deep_stop_entry <= 1'b0;
			rd(`OFS_CONTROL, r);
			chk("deep stop start field", r, 32'h48);
			rd(`OFS_STATUS, r);
			chk("deep stop run state", {30'h0, r[17:16]}, 32'h0);
		end
	endtask

	task automatic t_trigger;
		logic [31:0] r;
		int          seen;
		begin
			setup(16'h0040, 8'h68);
			seen = irq_count;
			pulse_source_inst.pulse(20, 20);
			chk("no irq on opposite edge", irq_count, seen);
			rd(`OFS_STATUS, r);
			chk("opposite edge halts", r[17:0], {2'h1, 16'h0});
			setup(16'h0003, 8'h28);
			seen = irq_count;
			rd(`OFS_STATUS, r);
			chk("armed before trigger", {30'h0, r[17:16]}, 32'h1);
			pulse_source_inst.pulse(14, 100);
			chk("match despite opposite edge", irq_count, seen + 1);
			rd(`OFS_STATUS, r);
			chk("halted after match", r[17:0], {2'h1, 16'h0});
		end
	endtask

	task automatic t_noise;
		logic [31:0] r;
		begin
			setup(16'h0040, 8'h28);
			pulse_source_inst.pulse(4, 20);
			rd(`OFS_STATUS, r);
			chk("short pulse rejected", {30'h0, r[17:16]}, 32'h1);
			power_mode <= timer_types_pkg::PWR_LOW_SPEED;
			pulse_source_inst.pulse(4, 20);
			rd(`OFS_STATUS, r);
			chk("filter bypassed", {30'h0, r[17:16]}, 32'h3);
			power_mode <= timer_types_pkg::PWR_NORMAL;
		end
	endtask

	task automatic t_event;
		int seen;
		begin
			setup(16'h0002, 8'h2C);
			seen = irq_count;
			pulse_source_inst.pulse(20, 20);
			pulse_source_inst.pulse(20, 0);
			chk("no match before fall", irq_count, seen);
			repeat (20) @(posedge pclk);
			chk("match at fall", irq_count, seen + 1);
			pulse_source_inst.pulse(20, 20);
			pulse_source_inst.pulse(20, 20);
			chk("event irq count", irq_count, seen + 2);
		end
	endtask

	// ==========================================================
	// Main sequence and verdict
	task automatic stop_test;
		begin
			$display("Checks %0d mismatches %0d", samples_checked, err_count);
			if (err_count == 0 && samples_checked > 0) begin
				$display("Run complete: PASS");
			end else begin
				$display("Run complete: FAIL");
			end
			$finish;
		end
	endtask

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_and_map();
		t_staged_bytes();
		t_timer_capture();
		t_trigger();
		t_noise();
		t_event();
		stop_test();
	end
endmodule
